//--- design/ccd_pkg.sv
// Package: descriptor tables, request codes and stream carriers for the module's USB identity
package ccd_pkg;

  // ---------------------------------------------------------------
  // Standard request decoding
  // ---------------------------------------------------------------
  localparam logic [7:0] CCD_REQTYPE_DEV_IN = 8'h80;
  localparam logic [7:0] CCD_REQ_GET_DESC   = 8'h06;
  localparam logic [7:0] CCD_DESC_DEVICE    = 8'h01;
  localparam logic [7:0] CCD_DESC_CONFIG    = 8'h02;
  localparam logic [7:0] CCD_DESC_STRING    = 8'h03;
  localparam logic [7:0] CCD_STR_COUNT      = 8'h04;

  // ---------------------------------------------------------------
  // Class codes and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] CCD_CLASS_MISC     = 8'hEF;
  localparam logic [7:0] CCD_DEV_SUBCLASS   = 8'h02;
  localparam logic [7:0] CCD_DEV_PROTOCOL   = 8'h01;
  localparam logic [7:0] CCD_FN_SUBCLASS    = 8'h07;
  localparam logic [7:0] CCD_PROTO_CMD      = 8'h01;
  localparam logic [7:0] CCD_PROTO_MEDIA    = 8'h02;
  localparam logic [1:0] CCD_ATTR_BULK      = 2'h2;
  localparam logic [6:0] CCD_EP0_MAX        = 7'h40;
  localparam logic [6:0] CCD_CMD_EP_MAX     = 7'h40;
  localparam logic [7:0] CCD_DEV_LEN        = 8'h12;
  localparam logic [7:0] CCD_CFG_LEN        = 8'h3F;
  localparam logic [7:0] CCD_LANG_LEN       = 8'h04;
  localparam logic [7:0] CCD_LANG_LO        = 8'h09;
  localparam logic [7:0] CCD_LANG_HI        = 8'h04;
  // Byte positions inside the tables, used by the checks
  localparam logic [6:0] CCD_POS_DEV_CLASS  = 7'h04;
  localparam logic [6:0] CCD_POS_IAD_CLASS  = 7'h0D;
  localparam logic [6:0] CCD_POS_CMD_PROTO  = 7'h18;
  localparam logic [6:0] CCD_POS_CMD_ATTR   = 7'h1D;
  localparam logic [6:0] CCD_POS_MED_PROTO  = 7'h2F;

  // Device descriptor; id bytes 8..11 are replaced by parameters
  localparam logic [7:0] CCD_DEV_ROM [18] = '{
    8'h12, 8'h01, 8'h00, 8'h02, 8'hEF, 8'h02, 8'h01, 8'h40, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};

  // Configuration: header, association, command and media interfaces
  localparam logic [7:0] CCD_CFG_ROM [63] = '{
    8'h09, 8'h02, 8'h3F, 8'h00, 8'h02, 8'h01, 8'h00, 8'h80, 8'h32,
    8'h08, 8'h0B, 8'h00, 8'h02, 8'hEF, 8'h07, 8'h00, 8'h01,
    8'h09, 8'h04, 8'h00, 8'h00, 8'h02, 8'hEF, 8'h07, 8'h01, 8'h02,
    8'h07, 8'h05, 8'h81, 8'h02, 8'h40, 8'h00, 8'h00,
    8'h07, 8'h05, 8'h01, 8'h02, 8'h40, 8'h00, 8'h00,
    8'h09, 8'h04, 8'h01, 8'h00, 8'h02, 8'hEF, 8'h07, 8'h02, 8'h03,
    8'h07, 8'h05, 8'h82, 8'h02, 8'h00, 8'h02, 8'h00,
    8'h07, 8'h05, 8'h02, 8'h02, 8'h00, 8'h02, 8'h00};

  // Text of strings 1..3 in ASCII, widened to UTF-16 on the fly
  localparam logic [7:0] CCD_TEXT [66] = '{
    8'h44, 8'h56, 8'h42, 8'h20, 8'h43, 8'h6F, 8'h6D, 8'h6D, 8'h6F, 8'h6E,
    8'h20, 8'h49, 8'h6E, 8'h74, 8'h65, 8'h72, 8'h66, 8'h61, 8'h63, 8'h65,
    8'h44, 8'h56, 8'h42, 8'h2D, 8'h43, 8'h49, 8'h20, 8'h43, 8'h6F, 8'h6D,
    8'h6D, 8'h61, 8'h6E, 8'h64, 8'h20, 8'h49, 8'h6E, 8'h74, 8'h65, 8'h72,
    8'h66, 8'h61, 8'h63, 8'h65,
    8'h44, 8'h56, 8'h42, 8'h2D, 8'h43, 8'h49, 8'h20, 8'h4D, 8'h65, 8'h64,
    8'h69, 8'h61, 8'h20, 8'h49, 8'h6E, 8'h74, 8'h65, 8'h72, 8'h66, 8'h61,
    8'h63, 8'h65};
  localparam logic [6:0] CCD_STR_BASE [4] = '{7'h00, 7'h00, 7'h14, 7'h2C};
  localparam logic [7:0] CCD_STR_CHARS [4] = '{8'h00, 8'h14, 8'h18, 8'h16};

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  req_type;
    logic [7:0]  request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } ccd_setup_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       zlp_ok;
  } ccd_src_t;

  typedef struct packed {
    logic [7:0] data;
    logic       pkt_end;
    logic       zlp;
  } ccd_pkt_t;

  typedef enum logic [1:0] {CCD_SEL_DEV, CCD_SEL_CFG, CCD_SEL_STR} ccd_sel_t;

endpackage

//--- design/ccd_desc_rom.sv
// Descriptor table lookup: byte and length of the selected descriptor
`timescale 1ns/1ps
module ccd_desc_rom
  import ccd_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID  = 16'h1234,  // Arbitrary value
  parameter logic [15:0] PRODUCT_ID = 16'h5678   // Arbitrary value
)
(
  input  wire ccd_pkg::ccd_sel_t sel,
  input  wire logic [1:0]        str_idx,
  input  wire logic [6:0]        addr,
  output logic [7:0]             data,
  output logic [7:0]             len
);

  logic [6:0] char_pos;
  logic [6:0] half;

  // ---------------------------------------------------------------
  // Table read
  // ---------------------------------------------------------------
  // Strings are kept as ASCII and widened here, which halves the table
  always_comb
  begin
    half     = 7'((addr - 7'h02) >> 1);
    char_pos = 7'(CCD_STR_BASE[str_idx] + half);
    data     = 8'h00;
    len      = 8'h00;
    unique case (sel)
      CCD_SEL_DEV:
      begin
        len = CCD_DEV_LEN;
        if (addr < 7'(CCD_DEV_LEN))
          data = CCD_DEV_ROM[addr[4:0]];
        if (addr == 7'h08) data = VENDOR_ID[7:0];
        if (addr == 7'h09) data = VENDOR_ID[15:8];
        if (addr == 7'h0A) data = PRODUCT_ID[7:0];
        if (addr == 7'h0B) data = PRODUCT_ID[15:8];
      end
      CCD_SEL_CFG:
      begin
        len = CCD_CFG_LEN;
        if (addr < 7'(CCD_CFG_LEN))
          data = CCD_CFG_ROM[addr[5:0]];
      end
      CCD_SEL_STR:
      begin
        if (str_idx == 2'h0)
        begin
          len = CCD_LANG_LEN;
          unique case (addr[1:0])
            2'h0: data = CCD_LANG_LEN;
            2'h1: data = CCD_DESC_STRING;
            2'h2: data = CCD_LANG_LO;
            2'h3: data = CCD_LANG_HI;
          endcase
        end
        else
        begin
          len = 8'(8'h02 + (CCD_STR_CHARS[str_idx] << 1));
          if (addr == 7'h00)
            data = len;
          else if (addr == 7'h01)
            data = CCD_DESC_STRING;
          else if (!addr[0] && addr < 7'(len))
            data = CCD_TEXT[char_pos];
        end
      end
      default:
      begin
        data = 8'h00;
        len  = 8'h00;
      end
    endcase
  end

endmodule

//--- design/ccd_packetizer.sv
// Splits a byte stream into full packets ending in a short or zero-length packet
`timescale 1ns/1ps
module ccd_packetizer
  import ccd_pkg::*;
#(
  parameter logic [6:0] MAX_PKT = CCD_EP0_MAX
)
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire ccd_pkg::ccd_src_t src,
  input  wire logic            src_valid,
  output logic                 src_ready,
  output ccd_pkg::ccd_pkt_t    pkt,
  output logic                 pkt_valid,
  input  wire logic            pkt_ready
);

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  ccd_pkt_t   next_pkt;
  logic       next_valid;
  logic       zlp_pend;
  logic       next_zlp_pend;
  logic       slot;
  logic       full;
  logic [7:0] beats;

  assign slot      = !pkt_valid || pkt_ready;
  assign src_ready = slot && !zlp_pend;
  assign full      = (cnt == 7'(MAX_PKT - 7'h01));

  // ---------------------------------------------------------------
  // Packet framing
  // ---------------------------------------------------------------
  // full packets, short or empty one closes
  always_comb
  begin
    next_cnt      = cnt;
    next_pkt      = pkt;
    next_valid    = pkt_valid && !pkt_ready;
    next_zlp_pend = zlp_pend;
    if (zlp_pend && slot)
    begin
      next_valid    = 1'b1;
      next_pkt      = '{data: 8'h00, pkt_end: 1'b1, zlp: 1'b1};
      next_zlp_pend = 1'b0;
    end
    else if (src_valid && src_ready)
    begin
      next_valid    = 1'b1;
      next_pkt      = '{data: src.data, pkt_end: src.last || full, zlp: 1'b0};
      next_cnt      = (src.last || full) ? 7'h00 : 7'(cnt + 7'h01);
      // A full last packet would look unfinished, so an empty one follows
      next_zlp_pend = src.last && full && src.zlp_ok;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt       <= 7'h00;
      pkt       <= '0;
      pkt_valid <= 1'b0;
      zlp_pend  <= 1'b0;
    end
    else
    begin
      cnt       <= next_cnt;
      pkt       <= next_pkt;
      pkt_valid <= next_valid;
      zlp_pend  <= next_zlp_pend;
    end
  end

  // Data beats already sent in the packet now on the output, for the checks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      beats <= 8'h00;
    else if (pkt_valid && pkt_ready)
      beats <= pkt.pkt_end ? 8'h00 : 8'(beats + 8'h01);
  end

  a_pkt_size_limit: assert property (
    @(posedge clk) disable iff (rst)
    pkt_valid && !pkt.zlp |-> beats < 8'(MAX_PKT) && (pkt.pkt_end || beats < 8'(MAX_PKT - 7'h01)))
    else $error("packet grew past its maximum size");

  a_zlp_follows: assert property (
    @(posedge clk) disable iff (rst)
    src_valid && src_ready && src.last && src.zlp_ok && full
      |=> zlp_pend && !src_ready ##[0:64] (pkt_valid && pkt.zlp && beats == 8'h00))
    else $error("full final packet not followed by an empty one");

  a_out_hold: assert property (
    @(posedge clk) disable iff (rst)
    pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt))
    else $error("packet byte changed while stalled");

  a_zlp_is_end: assert property (
    @(posedge clk) disable iff (rst)
    pkt_valid && pkt.zlp |-> pkt.pkt_end && pkt.data == 8'h00 && beats == 8'h00)
    else $error("empty packet malformed");

endmodule

//--- design/ccd_top.sv
// Top: enumeration descriptor server and command endpoint framing
`timescale 1ns/1ps

// Function
// - Device class EF, subclass 02, protocol 01
// - One association for the common-interface function
// - Other functions may add their own associations
// - Association reports class EF, subclass 07
// - Protocol 01 command, 02 media interface
// - Function string names the common-interface function
// - Command interface class EF, string named
// - Media interface class EF, string named
// - Networking interfaces use Ethernet emulation codes
// - Full packets, final one short or empty
// - Command bulk IN and OUT, 64 bytes
// - One session unit per command transfer
module ccd_top
  import ccd_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID  = 16'h1234,  // Arbitrary value
  parameter logic [15:0] PRODUCT_ID = 16'h5678   // Arbitrary value
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire ccd_pkg::ccd_setup_t setup,
  input  wire logic              setup_valid,
  output ccd_pkg::ccd_pkt_t      ep0_in,
  output logic                   ep0_in_valid,
  input  wire logic              ep0_in_ready,
  output logic                   ep0_stall,
  input  wire ccd_pkg::ccd_src_t cmd_tx,
  input  wire logic              cmd_tx_valid,
  output logic                   cmd_tx_ready,
  output ccd_pkg::ccd_pkt_t      cmd_in,
  output logic                   cmd_in_valid,
  input  wire logic              cmd_in_ready,
  input  wire ccd_pkg::ccd_pkt_t cmd_out,
  input  wire logic              cmd_out_valid,
  output logic                   cmd_out_ready,
  output logic [7:0]             cmd_rx_data,
  output logic                   cmd_rx_valid,
  output logic                   cmd_rx_last,
  output logic                   cmd_rx_empty,
  input  wire logic              cmd_rx_ready
);
  import ccd_pkg::*;

  typedef enum logic {CCD_IDLE, CCD_SEND} ccd_state_t;

  ccd_state_t state;
  ccd_state_t next_state;
  ccd_sel_t   sel;
  ccd_sel_t   next_sel;
  logic [1:0] str_idx;
  logic [1:0] next_str_idx;
  logic [6:0] pos;
  logic [6:0] next_pos;
  logic [7:0] total;
  logic [7:0] next_total;
  logic       zlp_ok;
  logic       next_zlp_ok;
  logic       next_stall;
  ccd_src_t   feed;
  logic       feed_ready;
  logic [7:0] rom_data;
  logic [7:0] rom_len;
  ccd_sel_t   req_sel;
  logic [1:0] req_idx;
  logic       req_ok;
  logic [7:0] req_len;
  logic [7:0] req_total;

  // ---------------------------------------------------------------
  // Descriptor table
  // ---------------------------------------------------------------
  // device class codes in the constant table
  // further associations would extend the table
  // networking not built, so no emulation interface
  ccd_desc_rom #(
    .VENDOR_ID  (VENDOR_ID),
    .PRODUCT_ID (PRODUCT_ID)
  ) u_rom (
    .sel     (setup_valid ? req_sel : sel),      // A new setup sizes its own answer
    .str_idx (setup_valid ? req_idx : str_idx),
    .addr    (pos),
    .data    (rom_data),
    .len     (rom_len)
  );

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  // only standard get-descriptor is served
  always_comb
  begin
    req_sel = CCD_SEL_DEV;
    req_idx = setup.value[1:0];
    req_ok  = 1'b0;
    if (setup.req_type == CCD_REQTYPE_DEV_IN && setup.request == CCD_REQ_GET_DESC)
    begin
      if (setup.value[15:8] == CCD_DESC_DEVICE && setup.value[7:0] == 8'h00)
        req_ok = 1'b1;
      if (setup.value[15:8] == CCD_DESC_CONFIG && setup.value[7:0] == 8'h00)
      begin
        req_sel = CCD_SEL_CFG;
        req_ok  = 1'b1;
      end
      // string table carries the function name
      if (setup.value[15:8] == CCD_DESC_STRING && setup.value[7:0] < CCD_STR_COUNT)
      begin
        req_sel = CCD_SEL_STR;
        req_ok  = 1'b1;
      end
    end
    req_len   = rom_len;
    // Host limit trims the answer; a shorter answer needs an end marker
    req_total = (setup.length < {8'h00, req_len}) ? setup.length[7:0] : req_len;
  end

  // ---------------------------------------------------------------
  // Descriptor send sequencer
  // ---------------------------------------------------------------
  // A new setup always supersedes an answer still in progress
  always_comb
  begin
    next_state   = state;
    next_sel     = sel;
    next_str_idx = str_idx;
    next_pos     = pos;
    next_total   = total;
    next_zlp_ok  = zlp_ok;
    next_stall   = 1'b0;
    if (setup_valid)
    begin
      next_sel     = req_sel;
      next_str_idx = req_idx;
      next_pos     = 7'h00;
      next_total   = req_total;
      next_zlp_ok  = {8'h00, req_len} < setup.length;
      next_stall   = !req_ok;
      next_state   = (req_ok && req_total != 8'h00) ? CCD_SEND : CCD_IDLE;
    end
    else
    begin
      unique case (state)
        CCD_IDLE:
          next_state = CCD_IDLE;
        CCD_SEND:
          if (feed_ready)
          begin
            next_pos = 7'(pos + 7'h01);
            if (feed.last)
              next_state = CCD_IDLE;
          end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state     <= CCD_IDLE;
      sel       <= CCD_SEL_DEV;
      str_idx   <= 2'h0;
      pos       <= 7'h00;
      total     <= 8'h00;
      zlp_ok    <= 1'b0;
      ep0_stall <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      sel       <= next_sel;
      str_idx   <= next_str_idx;
      pos       <= next_pos;
      total     <= next_total;
      zlp_ok    <= next_zlp_ok;
      ep0_stall <= next_stall;
    end
  end

  assign feed = '{data: rom_data, last: ({1'b0, pos} == 8'(total - 8'h01)), zlp_ok: zlp_ok};

  // control answer framed into endpoint-zero packets
  ccd_packetizer #(
    .MAX_PKT (CCD_EP0_MAX)
  ) u_ep0_pack (
    .clk       (clk),
    .rst       (rst),
    .src       (feed),
    .src_valid (state == CCD_SEND && !setup_valid),
    .src_ready (feed_ready),
    .pkt       (ep0_in),
    .pkt_valid (ep0_in_valid),
    .pkt_ready (ep0_in_ready)
  );

  // ---------------------------------------------------------------
  // Command IN endpoint
  // ---------------------------------------------------------------
  // Core's end flag is used as is; the empty-packet choice is always on
  ccd_src_t   cmd_feed;
  assign cmd_feed = '{data: cmd_tx.data, last: cmd_tx.last, zlp_ok: 1'b1};

  // bulk IN sized at 64 bytes
  // one session unit per transfer, empty packet if full
  ccd_packetizer #(
    .MAX_PKT (CCD_CMD_EP_MAX)
  ) u_cmd_pack (
    .clk       (clk),
    .rst       (rst),
    .src       (cmd_feed),
    .src_valid (cmd_tx_valid),
    .src_ready (cmd_tx_ready),
    .pkt       (cmd_in),
    .pkt_valid (cmd_in_valid),
    .pkt_ready (cmd_in_ready)
  );

  // ---------------------------------------------------------------
  // Command OUT endpoint
  // ---------------------------------------------------------------
  logic [6:0] rx_cnt;
  logic [6:0] next_rx_cnt;
  logic [7:0] next_rx_data;
  logic       next_rx_valid;
  logic       next_rx_last;
  logic       next_rx_empty;

  assign cmd_out_ready = !cmd_rx_valid || cmd_rx_ready;

  // a short or empty packet ends the session unit
  always_comb
  begin
    next_rx_cnt   = rx_cnt;
    next_rx_data  = cmd_rx_data;
    next_rx_valid = cmd_rx_valid && !cmd_rx_ready;
    next_rx_last  = cmd_rx_last;
    next_rx_empty = cmd_rx_empty;
    if (cmd_out_valid && cmd_out_ready)
    begin
      next_rx_valid = 1'b1;
      next_rx_data  = cmd_out.zlp ? 8'h00 : cmd_out.data;
      next_rx_empty = cmd_out.zlp;
      next_rx_last  = cmd_out.zlp ||
                      (cmd_out.pkt_end && rx_cnt != 7'(CCD_CMD_EP_MAX - 7'h01));
      next_rx_cnt   = (cmd_out.pkt_end || cmd_out.zlp) ? 7'h00 : 7'(rx_cnt + 7'h01);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_cnt       <= 7'h00;
      cmd_rx_data  <= 8'h00;
      cmd_rx_valid <= 1'b0;
      cmd_rx_last  <= 1'b0;
      cmd_rx_empty <= 1'b0;
    end
    else
    begin
      rx_cnt       <= next_rx_cnt;
      cmd_rx_data  <= next_rx_data;
      cmd_rx_valid <= next_rx_valid;
      cmd_rx_last  <= next_rx_last;
      cmd_rx_empty <= next_rx_empty;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_dev_class_code: assert property (
    @(posedge clk) disable iff (rst)
    !setup_valid && state == CCD_SEND && sel == CCD_SEL_DEV && pos == CCD_POS_DEV_CLASS
      |-> feed.data == CCD_CLASS_MISC)
    else $error("device class byte wrong");

  a_iad_class_code: assert property (
    @(posedge clk) disable iff (rst)
    !setup_valid && state == CCD_SEND && sel == CCD_SEL_CFG && pos == CCD_POS_IAD_CLASS
      |-> feed.data == CCD_CLASS_MISC)
    else $error("association class byte wrong");

  a_intf_protocols: assert property (
    @(posedge clk) disable iff (rst)
    !setup_valid && state == CCD_SEND && sel == CCD_SEL_CFG
      |-> (pos != CCD_POS_CMD_PROTO || feed.data == CCD_PROTO_CMD) &&
          (pos != CCD_POS_MED_PROTO || feed.data == CCD_PROTO_MEDIA))
    else $error("interface protocol byte wrong");

  a_cmd_ep_bulk: assert property (
    @(posedge clk) disable iff (rst)
    !setup_valid && state == CCD_SEND && sel == CCD_SEL_CFG &&
      (pos == CCD_POS_CMD_ATTR || pos == 7'(CCD_POS_CMD_ATTR + 7'h01))
      |-> ((pos == CCD_POS_CMD_ATTR) ? feed.data[1:0] == CCD_ATTR_BULK
                                     : feed.data == {1'b0, CCD_CMD_EP_MAX}))
    else $error("command endpoint not bulk");

  a_bad_req_stall: assert property (
    @(posedge clk) disable iff (rst)
    setup_valid && setup.request != CCD_REQ_GET_DESC |=> ep0_stall && state == CCD_IDLE)
    else $error("unsupported request not stalled");

  a_answer_length: assert property (
    @(posedge clk) disable iff (rst)
    setup_valid && req_ok && setup.length != 16'h0000
      |=> state == CCD_SEND && total != 8'h00 && {8'h00, total} <= setup.length)
    else $error("answer longer than the host asked for");

  a_rx_short_ends: assert property (
    @(posedge clk) disable iff (rst)
    cmd_out_valid && cmd_out_ready && cmd_out.pkt_end && rx_cnt < 7'h3F
      |=> cmd_rx_valid && cmd_rx_last)
    else $error("short packet did not end the unit");

endmodule

//--- tb/ccd_host_model.sv
// Host core model: takes endpoint-zero IN bytes, prompt or slow
`timescale 1ns/1ps
module ccd_host_model
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              slow,
  input  wire logic              clr,
  input  wire ccd_pkg::ccd_pkt_t ep0_in,
  input  wire logic              ep0_in_valid,
  output logic                   ep0_in_ready
);
  import ccd_pkg::*;
  logic [7:0] rx [256];
  int         n;
  logic       done;

  // Capture bytes; in slow mode ready drops every other cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ep0_in_ready <= 1'b0;
      n <= 0;
      done <= 1'b0;
    end
    else
    begin
      ep0_in_ready <= slow ? !ep0_in_ready : 1'b1;
      if (clr)
      begin
        n <= 0;
        done <= 1'b0;
      end
      // short or empty packet ends it
      else if (ep0_in_valid && ep0_in_ready)
      begin
        if (!ep0_in.zlp)
          rx[n[7:0]] <= ep0_in.data;
        n <= n + (ep0_in.zlp ? 0 : 1);
        if (ep0_in.pkt_end && (ep0_in.zlp || ((n + 1) % 64) != 0))
          done <= 1'b1;
      end
    end
  end
endmodule

//--- tb/tb_top.sv
// Bench top: descriptor reads, refusals and command framing
`timescale 1ns/1ps
module tb_top;
  import ccd_pkg::*;
  logic       clk, rst, slow, clr, setup_valid, ep0_in_valid, ep0_in_ready, ep0_stall;
  logic       cmd_tx_valid, cmd_tx_ready, cmd_in_valid, cmd_out_valid, cmd_out_ready;
  logic       cmd_rx_valid, cmd_rx_last, cmd_rx_empty;
  logic [7:0] cmd_rx_data;
  ccd_setup_t setup;
  ccd_pkt_t   ep0_in, cmd_in, cmd_out;
  ccd_src_t   cmd_tx;
  logic       st;
  int         failures, n_tests, in_n, in_end, in_zlp, rx_n, last_at, iad, rx_pos;

  ccd_top dut_u (.clk(clk), .rst(rst), .setup(setup), .setup_valid(setup_valid),
    .ep0_in(ep0_in), .ep0_in_valid(ep0_in_valid), .ep0_in_ready(ep0_in_ready),
    .ep0_stall(ep0_stall), .cmd_tx(cmd_tx), .cmd_tx_valid(cmd_tx_valid),
    .cmd_tx_ready(cmd_tx_ready), .cmd_in(cmd_in), .cmd_in_valid(cmd_in_valid),
    .cmd_in_ready(ep0_in_ready), .cmd_out(cmd_out), .cmd_out_valid(cmd_out_valid),
    .cmd_out_ready(cmd_out_ready), .cmd_rx_data(cmd_rx_data), .cmd_rx_valid(cmd_rx_valid),
    .cmd_rx_last(cmd_rx_last), .cmd_rx_empty(cmd_rx_empty), .cmd_rx_ready(1'b1));
  ccd_host_model host_u (.clk(clk), .rst(rst), .slow(slow), .clr(clr), .ep0_in(ep0_in),
    .ep0_in_valid(ep0_in_valid), .ep0_in_ready(ep0_in_ready));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // One setup pulse; st samples the stall pulse of the next cycle
  task automatic get_desc(input logic [7:0] rq, input logic [15:0] v, input logic [15:0] l);
    @(posedge clk);
    #1;
    setup = '{CCD_REQTYPE_DEV_IN, rq, v, 16'h0000, l};
    setup_valid = 1'b1;
    clr = 1'b1;
    @(posedge clk);
    #1;
    setup_valid = 1'b0;
    clr = 1'b0;
    st = ep0_stall;
    for (int i = 0; i < 400 && host_u.done !== 1'b1 && st !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  // Bytes of one unit or packet; held until taken
  task automatic send(input bit out, input int len);
    @(posedge clk);
    #1;
    for (int i = 0; i < len; i++)
    begin
      cmd_tx = '{8'(i), i == len - 1, 1'b1};
      cmd_out = '{8'(i), i == len - 1, 1'b0};
      cmd_tx_valid = !out;
      cmd_out_valid = out;
      @(negedge clk);
      while ((out ? cmd_out_ready : cmd_tx_ready) !== 1'b1)
        @(negedge clk);
      @(posedge clk);
      #1;
    end
    cmd_tx_valid = 1'b0;
    cmd_out_valid = 1'b0;
    repeat (20) @(posedge clk);
  endtask

  // Stream monitors of the command side
  always @(posedge clk)
  begin
    if (cmd_in_valid && ep0_in_ready && !rst)
    begin
      if (!cmd_in.zlp)
        chk(cmd_in.data, 8'(in_n % 64));
      in_n += !cmd_in.zlp;
      in_end += cmd_in.pkt_end && !cmd_in.zlp;
      in_zlp += cmd_in.zlp;
    end
    if (cmd_rx_valid && !rst)
    begin
      rx_n++;
      if (cmd_rx_empty !== 1'b1)
        chk(cmd_rx_data, 8'(rx_pos));
      rx_pos = (cmd_rx_last === 1'b1) ? 0 : rx_pos + 1;
      if (cmd_rx_last === 1'b1)
        last_at = rx_n;
    end
  end

  task automatic print_verdict;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Scenarios: device read with a slow host, then truncated
  task automatic t_dev;
    slow = 1'b1;
    get_desc(CCD_REQ_GET_DESC, 16'h0100, 16'h0040);
    chk(host_u.n[7:0], CCD_DEV_LEN);
    chk(host_u.rx[4], 8'hEF);
    chk(host_u.rx[5], 8'h02);
    chk(host_u.rx[6], 8'h01);
    get_desc(CCD_REQ_GET_DESC, 16'h0100, 16'h0008);
    chk(host_u.n[7:0], 8'h08);
    slow = 1'b0;
  endtask

  task automatic t_cfg;
    get_desc(CCD_REQ_GET_DESC, 16'h0200, 16'h00FF);
    chk(host_u.n[7:0], CCD_CFG_LEN);
    iad = 0;
    for (int p = 0; p < 63 && host_u.rx[p] !== 8'h00; p += host_u.rx[p])
      iad += (host_u.rx[p + 1] === 8'h0B);
    chk(8'(iad), 8'h01);
    chk(host_u.rx[13], 8'hEF);
    chk(host_u.rx[14], 8'h07);
    chk(host_u.rx[24], 8'h01);
    chk(host_u.rx[47], 8'h02);
    chk(host_u.rx[22], 8'hEF);
    chk(host_u.rx[45], 8'hEF);
    chk(host_u.rx[29] & 8'h03, 8'h02);
    chk(host_u.rx[30], 8'h40);
  endtask

  task automatic t_str_stall;
    get_desc(CCD_REQ_GET_DESC, 16'h0301, 16'h00FF);
    chk(host_u.rx[0], 8'h2A);
    chk(host_u.rx[2], 8'h44);
    chk(host_u.rx[3], 8'h00);
    get_desc(8'h00, 16'h0100, 16'h0040);
    chk(8'(st), 8'h01);
    get_desc(CCD_REQ_GET_DESC, 16'h0304, 16'h0040);
    chk(8'(st), 8'h01);
  endtask

  task automatic t_cmd;
    slow = 1'b1;
    send(1'b0, 64);
    send(1'b0, 3);
    chk(8'(in_n), 8'h43);
    chk(8'(in_end), 8'h02);
    chk(8'(in_zlp), 8'h01);
    send(1'b1, 3);
    chk(8'(rx_n), 8'h03);
    chk(8'(last_at), 8'h03);
    send(1'b1, 64);
    chk(8'(last_at), 8'h03);
    #1;
    cmd_out = '{8'h00, 1'b1, 1'b1};
    cmd_out_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_out_valid = 1'b0;
    chk(8'({cmd_rx_valid, cmd_rx_empty, cmd_rx_last}), 8'h07);
    @(posedge clk);
    #1;
    chk(8'(rx_n), 8'h44);
    chk(8'(last_at), 8'h44);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #300000;
    failures++;
    print_verdict();
  end

  initial
  begin
    {rst, slow, clr, setup_valid, cmd_tx_valid, cmd_out_valid} = 6'b10_0000;
    {failures, n_tests, in_n, in_end, in_zlp, rx_n, last_at, rx_pos} = '0;
    setup = '0;
    cmd_tx = '0;
    cmd_out = '0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_dev();
    t_cfg();
    t_str_stall();
    t_cmd();
    print_verdict();
  end
endmodule
